// ===== bench/psd_far_model.sv
// Far-side model: optical detector pulse trains and the controller inputs.
// Assumes one clock; a train starts with a pulse at the first edge of a run.
`timescale 1ns/1ps
module psd_far_model #(
	parameter int PULSE_CYC = 16
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  run,
	input  wire logic [1:0]  src,
	input  wire logic [19:0] per_cyc,
	input  wire logic [3:0]  preempt_sink,
	output logic      [3:0]  det_pri,
	output logic      [3:0]  det_aux1,
	output logic      [3:0]  det_aux2,
	output logic      [3:0]  ctl_in_n
);
	logic [19:0] cnt_ff;
	logic [19:0] nxt_cnt;
	logic [3:0]  train;

	// Pulse train, one period per per_cyc cycles
	always_comb
	begin
		nxt_cnt = cnt_ff + 20'h00001;
		if (run == 4'h0 || cnt_ff >= per_cyc - 20'h00001)
			nxt_cnt = 20'h00000;
		train = (run != 4'h0 && cnt_ff < 20'(PULSE_CYC)) ? run : 4'h0;
		det_pri = (src == 2'h0) ? train : 4'h0;
		det_aux1 = (src == 2'h1) ? train : 4'h0;
		det_aux2 = (src == 2'h2) ? train : 4'h0;
		ctl_in_n = ~preempt_sink;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_ff <= 20'h00000;
		else
			cnt_ff <= nxt_cnt;
	end
endmodule

// ===== bench/tb_preemption_signal_discriminator.sv
// Testbench for the discriminator: APB registers, test and radio calls, presence.
// Assumes TICK_CYC of 1, so one tick is one pclk cycle.
`timescale 1ns/1ps
module tb_preemption_signal_discriminator;
	localparam logic [7:0] OFS_BAD = 8'h18;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  det_pri, det_aux1, det_aux2, test_dn, test_up, gps_lo, gps_hi;
	logic [3:0]  preempt_sink, lamp_lo, lamp_hi, ctl_in_n, run;
	logic [15:0] range_sel;
	logic [4:0]  radio_chan;
	logic [1:0]  src;
	logic [19:0] per_cyc;
	int          fails, num_checks;

	psd_discriminator #(.TICK_CYC(1)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .det_pri(det_pri),
		.det_aux1(det_aux1), .det_aux2(det_aux2), .test_dn(test_dn), .test_up(test_up),
		.gps_lo(gps_lo), .gps_hi(gps_hi), .preempt_sink(preempt_sink), .lamp_lo(lamp_lo),
		.lamp_hi(lamp_hi), .range_sel(range_sel), .radio_chan(radio_chan), .irq(irq));
	psd_far_model far_u (.clk(pclk), .rst_n(presetn), .run(run), .src(src),
		.per_cyc(per_cyc), .preempt_sink(preempt_sink), .det_pri(det_pri),
		.det_aux1(det_aux1), .det_aux2(det_aux2), .ctl_in_n(ctl_in_n));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic test_done;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t pins got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; read data and error land in q and perr
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_state(input logic [31:0] m);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, psd_pkg::OFS_STATE, 32'h0);
			n++;
		end
		while ((q & m) !== m && n < 40000);
	endtask

	task automatic t_reset;
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk_reg(q, (i == 0) ? {20'h0, psd_pkg::CTRL_RST} : 32'h0);
		end
		@(negedge pclk);
		chk_pin(preempt_sink, 4'h0);
		chk_pin({3'h0, irq}, 4'h0);
		$display("reset values done");
	endtask

	task automatic t_regs;
		apb(1'b1, psd_pkg::OFS_RANGE, 32'h0000A5C3);
		apb(1'b0, psd_pkg::OFS_RANGE, 32'h0);
		chk_reg(q, 32'h0000A5C3);
		chk_reg({16'h0, range_sel}, 32'h0000A5C3);
		apb(1'b1, psd_pkg::OFS_RADIO, 32'h00000018);
		apb(1'b1, psd_pkg::OFS_RADIO, 32'h00000019);
		apb(1'b0, psd_pkg::OFS_RADIO, 32'h0);
		chk_reg(q, 32'h00000018);
		chk_reg({27'h0, radio_chan}, 32'h00000018);
		apb(1'b1, psd_pkg::OFS_STATE, 32'hFFFFFFFF);
		apb(1'b0, psd_pkg::OFS_STATE, 32'h0);
		chk_reg(q, 32'h0);
		apb(1'b0, OFS_BAD, 32'h0);
		chk_reg({q[30:0], perr}, 32'h00000001);
		$display("register access done");
	endtask

	task automatic t_gps_block;
		apb(1'b1, psd_pkg::OFS_CTRL, 32'h00000EF0);
		gps_hi <= 4'h1;
		repeat (40) @(posedge pclk);
		apb(1'b0, psd_pkg::OFS_STATE, 32'h0);
		chk_reg(q, 32'h0);
		gps_hi <= 4'h0;
		apb(1'b1, psd_pkg::OFS_CTRL, 32'h00000FF0);
		$display("radio disable done");
	endtask

	task automatic t_test_hi;
		int n;
		n = 0;
		test_up <= 4'h1;
		wait_state(32'h00010010);
		chk_reg(q & 32'h00010011, 32'h00010010);
		test_up <= 4'h0;
		repeat (300)
		begin
			@(negedge pclk);
			if (preempt_sink[0] === 1'b1)
				n++;
		end
		chk_reg(32'(n), 32'd300);
		chk_pin(lamp_hi & 4'h1, 4'h1);
		chk_pin(ctl_in_n, 4'hE);
		apb(1'b0, psd_pkg::OFS_STATE, 32'h0);
		chk_reg(q & 32'h00000010, 32'h00000010);
		$display("high test call done");
	endtask

	task automatic t_irq;
		apb(1'b0, psd_pkg::OFS_STATUS, 32'h0);
		chk_reg(q, 32'h00000010);
		chk_pin({3'h0, irq}, 4'h0);
		apb(1'b1, psd_pkg::OFS_MASK, 32'h00000011);
		@(negedge pclk);
		chk_pin({3'h0, irq}, 4'h1);
		apb(1'b1, psd_pkg::OFS_STATUS, 32'h00000010);
		@(negedge pclk);
		chk_pin({3'h0, irq}, 4'h0);
		$display("interrupt done");
	endtask

	task automatic t_lo_prec;
		apb(1'b1, psd_pkg::OFS_CTRL, 32'h00000FF1);
		gps_lo <= 4'h2;
		test_dn <= 4'h5;
		test_up <= 4'h4;
		wait_state(32'h00040043);
		chk_reg(q & 32'h00040063, 32'h00040043);
		@(negedge pclk);
		chk_pin(lamp_lo & 4'h3, 4'h3);
		chk_pin(preempt_sink & 4'h4, 4'h4);
		chk_pin({3'h0, irq}, 4'h1);
		@(posedge pclk);
		gps_lo <= 4'h0;
		test_dn <= 4'h0;
		test_up <= 4'h0;
		$display("low call and precedence done");
	endtask

	task automatic t_presence;
		src <= 2'h2;
		per_cyc <= 20'h11558;
		run <= 4'h8;
		wait_state(32'h00008000);
		chk_reg(q & 32'h00028880, 32'h00008000);
		run <= 4'h0;
		@(negedge pclk);
		chk_pin(lamp_hi & 4'h8, 4'h0);
		$display("presence done");
	endtask

	task automatic t_wave;
		int n;
		n = 0;
		while (preempt_sink[1] !== 1'b1 && n < 12000)
		begin
			@(negedge pclk);
			n++;
		end
		chk_pin(preempt_sink & 4'h2, 4'h2);
		chk_pin(lamp_hi & 4'h8, 4'h8);
		chk_pin(lamp_lo & 4'h2, 4'h2);
		$display("square wave done");
	endtask

	initial
	begin
		repeat (95000) @(posedge pclk);
		fails++;
		$display("[ERR] %0t timeout", $time);
		test_done;
	end

	initial
	begin
		fails = 0;
		num_checks = 0;
		presetn = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{test_dn, test_up, gps_lo, gps_hi, run} = 20'h00000;
		src = 2'h0;
		per_cyc = 20'h11558;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_regs;
		t_gps_block;
		t_test_hi;
		t_irq;
		t_lo_prec;
		t_presence;
		t_wave;
		test_done;
	end
endmodule

// ===== common/psd_pkg.sv
// Shared constants and types for the preemption signal discriminator.
// Assumes a 125 MHz pclk; all long times are counted in 1 us ticks.
package psd_pkg;

	localparam int CLK_NS   = 8;
	localparam int TICK_NS  = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int NCH      = 4;
	localparam int NDET     = 12;
	localparam int NRAW     = 28;
	localparam int PER_W    = 17;
	localparam int RUN_W    = 20;
	localparam int HOLD_W   = 24;
	localparam int TICK_W   = 12;

	// Code class rates in mHz, microseconds times mHz per second
	localparam int US_MHZ      = 1000000000;
	localparam int LO_F_MHZ    = 9639;
	localparam int LO_TOL_MHZ  = 119;
	localparam int HI_F_MHZ    = 14035;
	localparam int HI_TOL_MHZ  = 255;
	localparam int LO_FMAX     = LO_F_MHZ + LO_TOL_MHZ;
	localparam int LO_FMIN     = LO_F_MHZ - LO_TOL_MHZ;
	localparam int HI_FMAX     = HI_F_MHZ + HI_TOL_MHZ;
	localparam int HI_FMIN     = HI_F_MHZ - HI_TOL_MHZ;
	localparam logic [PER_W-1:0] LO_PMIN_US = PER_W'((US_MHZ + LO_FMAX - 1) / LO_FMAX);
	localparam logic [PER_W-1:0] LO_PMAX_US = PER_W'(US_MHZ / LO_FMIN);
	localparam logic [PER_W-1:0] HI_PMIN_US = PER_W'((US_MHZ + HI_FMAX - 1) / HI_FMAX);
	localparam logic [PER_W-1:0] HI_PMAX_US = PER_W'(US_MHZ / HI_FMIN);

	localparam int VALID_MS = 500;
	localparam logic [RUN_W-1:0] VALID_US = RUN_W'(VALID_MS * 1000);
	localparam int HOLD_SHORT_S = 5;
	localparam int HOLD_LONG_S  = 10;
	localparam logic [HOLD_W-1:0] HOLD_SHORT_US = HOLD_W'(HOLD_SHORT_S * 1000000);
	localparam logic [HOLD_W-1:0] HOLD_LONG_US  = HOLD_W'(HOLD_LONG_S * 1000000);
	localparam int WAVE_F_MHZ = 6250;
	localparam logic [PER_W-1:0] WAVE_HALF_US = PER_W'(US_MHZ / (2 * WAVE_F_MHZ));
	localparam logic [4:0] RADIO_CHANS = 5'h19;

	// Register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_RANGE  = 8'h04;
	localparam logic [7:0] OFS_RADIO  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MASK   = 8'h10;
	localparam logic [7:0] OFS_STATE  = 8'h14;

	// Control fields and reset values
	localparam int CTRL_HOLD_LSB = 0;
	localparam int CTRL_IR_LSB   = 4;
	localparam int CTRL_GPS_LSB  = 8;
	localparam logic [11:0] CTRL_RST  = 12'hFF0;
	localparam logic [15:0] RANGE_RST = 16'h0000;
	localparam logic [4:0]  RADIO_RST = 5'h00;
	localparam logic [7:0]  MASK_RST  = 8'h00;

	typedef struct packed {
		logic lo_sig;
		logic hi_sig;
		logic lo_val;
		logic hi_val;
	} psd_cls_t;

endpackage

// ===== hw/psd_discriminator.sv
// Four-channel preemption signal discriminator with APB registers.
// Assumes asynchronous detector, test and radio call pins; APB on pclk.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps

module psd_discriminator #(
	parameter int TICK_CYC = psd_pkg::TICK_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  det_pri,
	input  wire logic [3:0]  det_aux1,
	input  wire logic [3:0]  det_aux2,
	input  wire logic [3:0]  test_dn,
	input  wire logic [3:0]  test_up,
	input  wire logic [3:0]  gps_lo,
	input  wire logic [3:0]  gps_hi,
	output logic      [3:0]  preempt_sink,
	output logic      [3:0]  lamp_lo,
	output logic      [3:0]  lamp_hi,
	output logic      [15:0] range_sel,
	output logic      [4:0]  radio_chan,
	output logic             irq
);

	localparam int NCH = psd_pkg::NCH;

	logic [psd_pkg::NRAW-1:0]   raw;
	logic [psd_pkg::NRAW-1:0]   s1_ff;
	logic [psd_pkg::NRAW-1:0]   s2_ff;
	logic [psd_pkg::NDET-1:0]   s3_ff;
	logic [psd_pkg::NDET-1:0]   rise;
	logic [NCH-1:0]             test_dn_s;
	logic [NCH-1:0]             test_up_s;
	logic [NCH-1:0]             gps_lo_s;
	logic [NCH-1:0]             gps_hi_s;
	logic [psd_pkg::TICK_W-1:0] tick_cnt_ff;
	logic [psd_pkg::TICK_W-1:0] nxt_tick_cnt;
	logic                       tick;
	logic [psd_pkg::PER_W-1:0]  wave_cnt_ff;
	logic [psd_pkg::PER_W-1:0]  nxt_wave_cnt;
	logic                       wave_ff;
	logic                       nxt_wave;
	psd_pkg::psd_cls_t          cls [psd_pkg::NDET];
	logic [NCH-1:0]             lo_src;
	logic [NCH-1:0]             hi_src;
	logic [NCH-1:0]             lo_call;
	logic [NCH-1:0]             hi_call;
	logic [NCH-1:0]             lo_rise;
	logic [NCH-1:0]             hi_rise;
	logic [NCH-1:0]             lo_sig;
	logic [NCH-1:0]             hi_sig;
	logic [11:0]                ctrl_ff;
	logic [11:0]                nxt_ctrl;
	logic [15:0]                range_ff;
	logic [15:0]                nxt_range;
	logic [4:0]                 radio_ff;
	logic [4:0]                 nxt_radio;
	logic [7:0]                 status_ff;
	logic [7:0]                 nxt_status;
	logic [7:0]                 mask_ff;
	logic [7:0]                 nxt_mask;
	logic [31:0]                prdata_ff;
	logic [31:0]                nxt_prdata;
	logic [31:0]                rdata;
	logic                       mapped;
	logic                       wr;
	logic [NCH-1:0]             hold10;
	logic [NCH-1:0]             ir_en;
	logic [NCH-1:0]             gps_en;

	// Pin synchronisers; edges are taken from the second stage
	assign raw = {gps_hi, gps_lo, test_up, test_dn, det_aux2, det_aux1, det_pri};
	assign rise      = s2_ff[psd_pkg::NDET-1:0] & ~s3_ff;
	assign test_dn_s = s2_ff[15:12];
	assign test_up_s = s2_ff[19:16];
	assign gps_lo_s  = s2_ff[23:20];
	assign gps_hi_s  = s2_ff[27:24];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end
		else if (ce)
		begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff[psd_pkg::NDET-1:0];
		end
	end

	// Microsecond tick and the output square wave
	assign tick = (tick_cnt_ff == psd_pkg::TICK_W'(TICK_CYC - 1));

	always_comb
	begin
		nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
		nxt_wave_cnt = wave_cnt_ff;
		nxt_wave     = wave_ff;
		if (tick)
		begin
			if (wave_cnt_ff == psd_pkg::WAVE_HALF_US - 1'b1)
			begin
				nxt_wave_cnt = '0;
				nxt_wave     = ~wave_ff;
			end
			else
				nxt_wave_cnt = wave_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt_ff <= '0;
			wave_cnt_ff <= '0;
			wave_ff     <= 1'b0;
		end
		else if (ce)
		begin
			tick_cnt_ff <= nxt_tick_cnt;
			wave_cnt_ff <= nxt_wave_cnt;
			wave_ff     <= nxt_wave;
		end
	end

	// Detector inputs: k = channel + 4 * (0 primary, 1 aux 1, 2 aux 2)
	for (genvar k = 0; k < psd_pkg::NDET; k++)
	begin : g_det
		psd_rate_classifier u_cls (
			.clk   (pclk),
			.rst_n (presetn),
			.ce    (ce),
			.tick  (tick),
			.rise  (rise[k]),
			.cls   (cls[k])
		);
	end

	assign hold10 = ctrl_ff[psd_pkg::CTRL_HOLD_LSB +: NCH];
	assign ir_en  = ctrl_ff[psd_pkg::CTRL_IR_LSB +: NCH];
	assign gps_en = ctrl_ff[psd_pkg::CTRL_GPS_LSB +: NCH];

	// Per-channel merge, hold, output and lamps
	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		logic [psd_pkg::HOLD_W-1:0] hold_lo_ff;
		logic [psd_pkg::HOLD_W-1:0] nxt_hold_lo;
		logic [psd_pkg::HOLD_W-1:0] hold_hi_ff;
		logic [psd_pkg::HOLD_W-1:0] nxt_hold_hi;
		logic [psd_pkg::HOLD_W-1:0] reload;
		logic                       call_lo_ff;
		logic                       nxt_call_lo;
		logic                       call_hi_ff;
		logic                       nxt_call_hi;
		logic                       sink_ff;
		logic                       nxt_sink;
		logic                       lamp_lo_ff;
		logic                       nxt_lamp_lo;
		logic                       lamp_hi_ff;
		logic                       nxt_lamp_hi;

		always_comb
		begin
			lo_src[c] = (ir_en[c] && (cls[c].lo_val || cls[c + 4].lo_val
				|| cls[c + 8].lo_val)) || (gps_en[c] && gps_lo_s[c]) || test_dn_s[c];
			hi_src[c] = (ir_en[c] && (cls[c].hi_val || cls[c + 4].hi_val
				|| cls[c + 8].hi_val)) || (gps_en[c] && gps_hi_s[c]) || test_up_s[c];
			lo_sig[c] = ir_en[c] && (cls[c].lo_sig || cls[c + 4].lo_sig || cls[c + 8].lo_sig);
			hi_sig[c] = ir_en[c] && (cls[c].hi_sig || cls[c + 4].hi_sig || cls[c + 8].hi_sig);
			reload = hold10[c] ? psd_pkg::HOLD_LONG_US : psd_pkg::HOLD_SHORT_US;
			nxt_hold_lo = hold_lo_ff;
			nxt_hold_hi = hold_hi_ff;
			if (lo_src[c])
				nxt_hold_lo = reload;
			else if (tick && (hold_lo_ff != '0))
				nxt_hold_lo = hold_lo_ff - 1'b1;
			if (hi_src[c])
				nxt_hold_hi = reload;
			else if (tick && (hold_hi_ff != '0))
				nxt_hold_hi = hold_hi_ff - 1'b1;
			nxt_call_lo = lo_src[c] || (nxt_hold_lo != '0);
			nxt_call_hi = hi_src[c] || (nxt_hold_hi != '0);
			nxt_sink    = nxt_call_hi || (nxt_call_lo && nxt_wave);
			nxt_lamp_lo = nxt_call_lo || (lo_sig[c] && nxt_wave);
			nxt_lamp_hi = nxt_call_hi || (hi_sig[c] && nxt_wave);
			lo_rise[c]  = nxt_call_lo && !call_lo_ff;
			hi_rise[c]  = nxt_call_hi && !call_hi_ff;
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				hold_lo_ff <= '0;
				hold_hi_ff <= '0;
				call_lo_ff <= 1'b0;
				call_hi_ff <= 1'b0;
				sink_ff    <= 1'b0;
				lamp_lo_ff <= 1'b0;
				lamp_hi_ff <= 1'b0;
			end
			else if (ce)
			begin
				hold_lo_ff <= nxt_hold_lo;
				hold_hi_ff <= nxt_hold_hi;
				call_lo_ff <= nxt_call_lo;
				call_hi_ff <= nxt_call_hi;
				sink_ff    <= nxt_sink;
				lamp_lo_ff <= nxt_lamp_lo;
				lamp_hi_ff <= nxt_lamp_hi;
			end
		end

		assign lo_call[c]      = call_lo_ff;
		assign hi_call[c]      = call_hi_ff;
		assign preempt_sink[c] = sink_ff;
		assign lamp_lo[c]      = lamp_lo_ff;
		assign lamp_hi[c]      = lamp_hi_ff;
	end

	// APB slave, zero wait states
	assign wr = psel && penable && pwrite;

	always_comb
	begin
		mapped = 1'b1;
		rdata  = '0;
		case (paddr)
			psd_pkg::OFS_CTRL:   rdata = {20'h00000, ctrl_ff};
			psd_pkg::OFS_RANGE:  rdata = {16'h0000, range_ff};
			psd_pkg::OFS_RADIO:  rdata = {27'h0000000, radio_ff};
			psd_pkg::OFS_STATUS: rdata = {24'h000000, status_ff};
			psd_pkg::OFS_MASK:   rdata = {24'h000000, mask_ff};
			psd_pkg::OFS_STATE:  rdata = {12'h000, preempt_sink, hi_sig, lo_sig, hi_call, lo_call};
			default:             mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		nxt_ctrl   = ctrl_ff;
		nxt_range  = range_ff;
		nxt_radio  = radio_ff;
		nxt_mask   = mask_ff;
		nxt_prdata = prdata_ff;
		nxt_status = status_ff;
		if (psel && !penable && !pwrite)
			nxt_prdata = rdata;
		if (wr)
		begin
			case (paddr)
				psd_pkg::OFS_CTRL:   nxt_ctrl = pwdata[11:0];
				psd_pkg::OFS_RANGE:  nxt_range = pwdata[15:0];
				psd_pkg::OFS_RADIO:
				begin
					if (pwdata[31:0] < {27'h0000000, psd_pkg::RADIO_CHANS})
						nxt_radio = pwdata[4:0];
				end
				psd_pkg::OFS_STATUS: nxt_status = status_ff & ~pwdata[7:0];
				psd_pkg::OFS_MASK:   nxt_mask = pwdata[7:0];
				default:             nxt_mask = mask_ff;
			endcase
		end
		// New calls set status after the clear so the set wins
		nxt_status = nxt_status | {hi_rise, lo_rise};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff   <= psd_pkg::CTRL_RST;
			range_ff  <= psd_pkg::RANGE_RST;
			radio_ff  <= psd_pkg::RADIO_RST;
			status_ff <= '0;
			mask_ff   <= psd_pkg::MASK_RST;
			prdata_ff <= '0;
		end
		else if (ce)
		begin
			ctrl_ff   <= nxt_ctrl;
			range_ff  <= nxt_range;
			radio_ff  <= nxt_radio;
			status_ff <= nxt_status;
			mask_ff   <= nxt_mask;
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata     = prdata_ff;
	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !mapped;
	assign range_sel  = range_ff;
	assign radio_chan = radio_ff;
	assign irq        = |(status_ff & mask_ff);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !ce);

	sequence lo_src_drops;
		lo_src[0] ##1 !lo_src[0];
	endsequence

	hi_steady_a: assert property (!(|(hi_call & ~preempt_sink)))
		else $error("high-rate call without steady output");
	lo_wave_a: assert property (((lo_call & ~hi_call) & (preempt_sink ^ {4{wave_ff}})) == 4'h0)
		else $error("low-rate output does not follow square wave");
	wave_half_a: assert property ($changed(wave_ff) |-> $past(wave_cnt_ff) == psd_pkg::WAVE_HALF_US - 1'b1)
		else $error("square wave half period wrong");
	hold_reload_a: assert property (lo_src[0] |=> g_ch[0].hold_lo_ff ==
		(ctrl_ff[psd_pkg::CTRL_HOLD_LSB] ? psd_pkg::HOLD_LONG_US : psd_pkg::HOLD_SHORT_US))
		else $error("hold time not reloaded");
	hold_keep_a: assert property (lo_src_drops |-> lo_call[0] [*8])
		else $error("call dropped at input loss");
	test_call_a: assert property (test_up_s[0] |=> hi_call[0] && preempt_sink[0])
		else $error("test switch up did not force high-rate call");
	status_set_a: assert property ($rose(lo_call[0]) |-> status_ff[0])
		else $error("call start not flagged");
	radio_range_a: assert property (radio_ff < psd_pkg::RADIO_CHANS)
		else $error("radio channel out of range");
	irq_level_a: assert property (|({hi_rise, lo_rise} & mask_ff) && !(wr && (paddr == psd_pkg::OFS_MASK))
		|=> irq)
		else $error("interrupt level mismatch");

endmodule

// ===== hw/psd_rate_classifier.sv
// Period classifier for one detector input.
// Assumes a synchronised rising-edge pulse and a 1 us tick on the same clock.
`timescale 1ns/1ps
module psd_rate_classifier (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             tick,
	input  wire logic             rise,
	output psd_pkg::psd_cls_t     cls
);

	logic [psd_pkg::PER_W-1:0] per_ff;
	logic [psd_pkg::PER_W-1:0] nxt_per;
	logic [psd_pkg::RUN_W-1:0] lo_run_ff;
	logic [psd_pkg::RUN_W-1:0] nxt_lo_run;
	logic [psd_pkg::RUN_W-1:0] hi_run_ff;
	logic [psd_pkg::RUN_W-1:0] nxt_hi_run;
	logic                      lo_sig_ff;
	logic                      nxt_lo_sig;
	logic                      hi_sig_ff;
	logic                      nxt_hi_sig;
	logic                      in_lo;
	logic                      in_hi;

	always_comb
	begin
		nxt_per    = per_ff;
		nxt_lo_run = lo_run_ff;
		nxt_hi_run = hi_run_ff;
		nxt_lo_sig = lo_sig_ff;
		nxt_hi_sig = hi_sig_ff;
		in_lo = (per_ff >= psd_pkg::LO_PMIN_US) && (per_ff <= psd_pkg::LO_PMAX_US);
		in_hi = (per_ff >= psd_pkg::HI_PMIN_US) && (per_ff <= psd_pkg::HI_PMAX_US);
		if (tick && (per_ff != '1))
			nxt_per = per_ff + 1'b1;
		if (rise)
		begin
			nxt_per    = '0;
			nxt_lo_sig = in_lo;
			nxt_hi_sig = in_hi;
			// Runs restart on any off-class period, so mixed trains never qualify
			if (!in_lo)
				nxt_lo_run = '0;
			else if (lo_run_ff <= psd_pkg::VALID_US)
				nxt_lo_run = lo_run_ff + psd_pkg::RUN_W'(per_ff);
			if (!in_hi)
				nxt_hi_run = '0;
			else if (hi_run_ff <= psd_pkg::VALID_US)
				nxt_hi_run = hi_run_ff + psd_pkg::RUN_W'(per_ff);
		end
		else
		begin
			if (per_ff > psd_pkg::HI_PMAX_US)
			begin
				nxt_hi_sig = 1'b0;
				nxt_hi_run = '0;
			end
			if (per_ff > psd_pkg::LO_PMAX_US)
			begin
				nxt_lo_sig = 1'b0;
				nxt_lo_run = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			per_ff    <= '1;
			lo_run_ff <= '0;
			hi_run_ff <= '0;
			lo_sig_ff <= 1'b0;
			hi_sig_ff <= 1'b0;
		end
		else if (ce)
		begin
			per_ff    <= nxt_per;
			lo_run_ff <= nxt_lo_run;
			hi_run_ff <= nxt_hi_run;
			lo_sig_ff <= nxt_lo_sig;
			hi_sig_ff <= nxt_hi_sig;
		end
	end

	assign cls.lo_sig = lo_sig_ff;
	assign cls.hi_sig = hi_sig_ff;
	assign cls.lo_val = lo_sig_ff && (lo_run_ff > psd_pkg::VALID_US);
	assign cls.hi_val = hi_sig_ff && (hi_run_ff > psd_pkg::VALID_US);

	one_class_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(lo_sig_ff && hi_sig_ff))
		else $error("period matched both code classes");
	lost_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !rise && (per_ff > psd_pkg::LO_PMAX_US) |=> !cls.lo_val && !cls.hi_val)
		else $error("call valid after input lost");

endmodule
